// File: amm_ctrl_top.sv
// amplifier monitor, silence control and serial command interpreter
// assumes one 100 MHz clock, async serial and silence pins, sensor inputs on clk
`timescale 1ns/100ps
`include "amm_defines.svh"
module amm_ctrl_top #(
  parameter int          BIT_CYC   = `AMM_BIT_CYC,
  parameter logic [31:0] PART_NUM  = "PN00",  // arbitrary
  parameter logic [31:0] SW_VER    = "0.00",  // arbitrary
  parameter logic [31:0] SERIAL_NO = "SN00"   // arbitrary
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire logic [3:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic [31:0]              avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire logic                rxd_i,
  output logic                     txd_o,
  input  wire logic                mute_pin_i,
  output logic                     pull_up_en_o,
  output logic                     pull_down_en_o,
  output logic                     pa_en_o,
  input  wire amm_pkg::amm_char_t  temp_i,
  input  wire amm_pkg::amm_char_t  fwdpwr_i,
  input  wire logic                pll_unlock_i
);
  import amm_pkg::*;

  localparam int CW = $clog2(BIT_CYC + 1);
  localparam int LW = 8 * `AMM_LINE_MAX;
  localparam int RW = 8 * `AMM_REPLY_BYTES;
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);

  // sign and three digits, leading zeros suppressed as nul bytes
  function automatic logic [31:0] dec_txt(input logic [7:0] v);
    logic [7:0] m;
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] o;
    m = v[7] ? 8'(-v) : v;
    h = m / 8'h64;
    t = (m / 8'h0A) % 8'h0A;
    o = m % 8'h0A;
    dec_txt = {v[7] ? `AMM_CH_MINUS : 8'h00,
               (h != 8'h00) ? (`AMM_CH_ZERO + h) : 8'h00,
               (h != 8'h00 || t != 8'h00) ? (`AMM_CH_ZERO + t) : 8'h00,
               `AMM_CH_ZERO + o};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              rx_s1_q, rx_s2_q, pin_s1_q, pin_s2_q;
  amm_rx_t           rx_st_q;
  logic [CW-1:0]     rx_cnt_q, tx_cnt_q;
  logic [2:0]        rx_bit_q;
  logic [3:0]        tx_bit_q;
  logic [7:0]        rx_sh_q;
  logic              rx_valid_q;
  logic [LW-1:0]     line_q;
  logic [4:0]        len_q;
  logic              ovf_q, pend_q;
  logic [RW-1:0]     reply_q;
  logic [9:0]        tx_sh_q;
  logic              tx_busy_q;
  logic [1:0]        ctrl_q;
  logic              sw_mute_q, ot_q, pll_q, mute_q;

  // ----------------------------------------------------------------
  // silence path
  // ----------------------------------------------------------------
  wire pin_mute = ctrl_q[`AMM_CTRL_POL] ? pin_s2_q : ~pin_s2_q;
  wire mute_d   = sw_mute_q | pin_mute;

  always_ff @(posedge clk_sys_i)
  begin
    pin_s1_q <= mute_pin_i;
    pin_s2_q <= pin_s1_q;
    rx_s1_q  <= rxd_i;
    rx_s2_q  <= rx_s1_q;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      mute_q         <= 1'b0;
      pa_en_o        <= 1'b0;
      pull_up_en_o   <= 1'b0;
      pull_down_en_o <= 1'b1;
    end
    else
    begin
      mute_q         <= mute_d;
      pa_en_o        <= ~mute_d;
      pull_up_en_o   <= ctrl_q[`AMM_CTRL_PULLUP];
      pull_down_en_o <= ~ctrl_q[`AMM_CTRL_PULLUP];
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  wire        acc     = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  wire        wr_ctrl = ~avs_waitrequest_o & avs_write_i & avs_byteenable_i[0] &
                        (avs_address_i == `AMM_ADDR_CTRL);
  wire [31:0] rd_mux  =
    (avs_address_i == `AMM_ADDR_CTRL) ? {30'h0, ctrl_q} :
    (avs_address_i == `AMM_ADDR_STAT) ? {27'h0, pin_mute, sw_mute_q, pll_q, ot_q, mute_q} :
    (avs_address_i == `AMM_ADDR_TEMP) ? {{24{temp_i[7]}}, temp_i} : 32'h0;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
      ctrl_q            <= `AMM_CTRL_RST;
    end
    else
    begin
      avs_waitrequest_o <= ~acc;
      if (acc & avs_read_i)
        avs_readdata_o <= rd_mux;
      if (wr_ctrl)
        ctrl_q <= avs_writedata_i[1:0];
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rx_st_q    <= RX_IDLE;
      rx_cnt_q   <= '0;
      rx_bit_q   <= 3'h0;
      rx_sh_q    <= 8'h00;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= 1'b0;
      rx_cnt_q   <= (rx_cnt_q != '0) ? rx_cnt_q - 1'b1 : FULL;
      unique case (rx_st_q)
        RX_IDLE:
        begin
          rx_cnt_q <= HALF;
          if (!rx_s2_q)
            rx_st_q <= RX_START;
        end
        RX_START:
          if (rx_cnt_q == '0)
            rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (rx_cnt_q == '0)
          begin
            rx_sh_q  <= {rx_s2_q, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7)
              rx_st_q <= RX_STOP;
          end
        RX_STOP:
          if (rx_cnt_q == '0)
          begin
            rx_st_q    <= RX_IDLE;
            rx_valid_q <= rx_s2_q;
          end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire        go       = pend_q & ~tx_busy_q & (reply_q == '0);
  wire [63:0] head8    = 64'(line_q >> (8 * (len_q - 5'h08)));
  wire        is_ident = ~ovf_q & (line_q == LW'("getident"));
  wire        is_stat  = ~ovf_q & (line_q == LW'("getstatus"));
  wire        is_flt   = ~ovf_q & (line_q == LW'("getfaults"));
  wire        is_rst   = ~ovf_q & (line_q == LW'("resetfaults"));
  wire        sm_miss  = ~ovf_q & ((line_q == LW'("setmute")) |
                                   (line_q == LW'("setmute cmd")));
  wire        sm_full  = ~ovf_q & (line_q[LW-1:8] == (LW-8)'("setmute cmd "));
  wire        sm_good  = sm_full & (line_q[7:1] == 7'(`AMM_CH_ZERO >> 1));
  wire        sm_head  = ~ovf_q & (len_q >= 5'h08) & (head8 == "setmute ");
  wire        do_rst   = go & is_rst;

  // ----------------------------------------------------------------
  // replies, right aligned; nul bytes are skipped when sending
  // ----------------------------------------------------------------
  wire [7:0]    flt_ch = `AMM_CH_ZERO | {7'h0, ot_q | pll_q};
  wire [RW-1:0] r_id   = RW'({`AMM_CRLF, "ok pn ", PART_NUM, " swver ", SW_VER,
                              " sn ", SERIAL_NO, `AMM_CRLF});
  wire [RW-1:0] r_st   = RW'({`AMM_CRLF, "ok fault ", flt_ch, " fwdpwr ",
                              dec_txt(fwdpwr_i), " revpwr 0 temp ",
                              dec_txt(temp_i), `AMM_CRLF});
  wire [RW-1:0] r_fl   = RW'({`AMM_CRLF, "ok mute ", `AMM_CH_ZERO | {7'h0, mute_q},
                              " overTemp ", `AMM_CH_ZERO | {7'h0, ot_q},
                              " pll ", `AMM_CH_ZERO | {7'h0, pll_q},
                              `AMM_CRLF});
  wire [RW-1:0] r_ok   = RW'({`AMM_CRLF, "ok", `AMM_CRLF});
  wire [RW-1:0] reply_d =
    is_ident ? r_id :
    is_stat  ? r_st :
    is_flt   ? r_fl :
    (is_rst | sm_good) ? r_ok :
    sm_miss  ? RW'({`AMM_CRLF, "err Missing Parameter", `AMM_CRLF}) :
    sm_full  ? RW'({`AMM_CRLF, "err Invalid Value", `AMM_CRLF}) :
    sm_head  ? RW'({`AMM_CRLF, "err Invalid Parameter", `AMM_CRLF}) :
               RW'({`AMM_CRLF, "err Invalid Command", `AMM_CRLF});

  // ----------------------------------------------------------------
  // line buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || go)
    begin
      line_q <= '0;
      len_q  <= 5'h0;
      ovf_q  <= 1'b0;
      pend_q <= 1'b0;
    end
    else if (rx_valid_q && !pend_q)
    begin
      if (rx_sh_q == `AMM_CH_CR)
        pend_q <= 1'b1;
      else if (rx_sh_q != `AMM_CH_LF)
      begin
        line_q <= {line_q[LW-9:0], rx_sh_q};
        if (len_q == 5'(`AMM_LINE_MAX))
          ovf_q <= 1'b1;
        else
          len_q <= len_q + 5'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      reply_q   <= '0;
      tx_sh_q   <= 10'h3FF;
      tx_busy_q <= 1'b0;
      tx_bit_q  <= 4'h0;
      tx_cnt_q  <= '0;
      txd_o     <= 1'b1;
    end
    else
    begin
      txd_o <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      if (go)
        reply_q <= reply_d;
      else if (!tx_busy_q && reply_q != '0)
      begin
        reply_q <= {reply_q[RW-9:0], 8'h00};
        if (reply_q[RW-1:RW-8] != 8'h00)
        begin
          tx_sh_q   <= {1'b1, reply_q[RW-1:RW-8], 1'b0};
          tx_busy_q <= 1'b1;
          tx_bit_q  <= 4'h0;
          tx_cnt_q  <= FULL;
        end
      end
      else if (tx_busy_q)
      begin
        tx_cnt_q <= (tx_cnt_q != '0) ? tx_cnt_q - 1'b1 : FULL;
        if (tx_cnt_q == '0)
        begin
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == 4'h9)
            tx_busy_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // faults and software silence
  // ----------------------------------------------------------------
  wire ot_hot  = $signed(temp_i) > `AMM_OT_TRIP;
  wire ot_cool = $signed(temp_i) < `AMM_OT_RESET;
  wire ot_low  = $signed(temp_i) < `AMM_OT_TRIP;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ot_q      <= 1'b0;
      pll_q     <= 1'b0;
      sw_mute_q <= 1'b0;
    end
    else
    begin
      if (ot_hot)
        ot_q <= 1'b1;
      else if (ot_cool || (do_rst && ot_low))
        ot_q <= 1'b0;
      if (pll_unlock_i)
        pll_q <= 1'b1;
      else if (do_rst)
        pll_q <= 1'b0;
      if (go && sm_good)
        sw_mute_q <= line_q[0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_sw_mute;
    @(posedge clk_sys_i) disable iff (rst_i) sw_mute_q |=> !pa_en_o;
  endproperty
  a_sw_mute: assert property (p_sw_mute) else $error("pa enabled under sw mute");

  property p_pol_high;
    @(posedge clk_sys_i) disable iff (rst_i)
      (ctrl_q == 2'h1 && !sw_mute_q && !pin_s2_q) |=> pa_en_o;
  endproperty
  a_pol_high: assert property (p_pol_high) else $error("low pin silenced");

  property p_pol_low;
    @(posedge clk_sys_i) disable iff (rst_i)
      (!ctrl_q[0] && !pin_s2_q) |=> !pa_en_o;
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("active low not honoured");

  property p_bias;
    @(posedge clk_sys_i) disable iff (rst_i)
      $changed(ctrl_q[1]) |=> pull_up_en_o == ctrl_q[1] && pull_down_en_o != pull_up_en_o;
  endproperty
  a_bias: assert property (p_bias) else $error("bias outputs wrong");

  property p_ot_set;
    @(posedge clk_sys_i) disable iff (rst_i) ot_hot |=> ot_q;
  endproperty
  a_ot_set: assert property (p_ot_set) else $error("overtemp not set");

  property p_ot_hold;
    @(posedge clk_sys_i) disable iff (rst_i) (ot_q && !ot_low) |=> ot_q;
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("overtemp cleared at trip");

  property p_pll_latch;
    @(posedge clk_sys_i) disable iff (rst_i) (pll_q && !do_rst) |=> pll_q;
  endproperty
  a_pll_latch: assert property (p_pll_latch) else $error("lock loss lost");

  property p_clr_keeps_mute;
    @(posedge clk_sys_i) disable iff (rst_i) (do_rst && sw_mute_q) |=> sw_mute_q;
  endproperty
  a_clr_keeps_mute: assert property (p_clr_keeps_mute) else $error("clear undid mute");

  property p_quiet;
    @(posedge clk_sys_i) disable iff (rst_i)
      (reply_q == '0 && !pend_q && !tx_busy_q) |=> !tx_busy_q ##1 txd_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("unsolicited transmit");

  property p_frame;
    @(posedge clk_sys_i) disable iff (rst_i) go |=> reply_q[15:0] == `AMM_CRLF;
  endproperty
  a_frame: assert property (p_frame) else $error("reply not framed");

endmodule // amm_ctrl_top

// File: amm_defines.svh
// constants of the amplifier monitor and silence controller
// assumes a 100 MHz system clock and a 32-bit avalon-mm register port
`ifndef AMM_DEFINES_SVH
`define AMM_DEFINES_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define AMM_CLK_HZ      100000000
`define AMM_BAUD        9600
`define AMM_BIT_CYC     (`AMM_CLK_HZ / `AMM_BAUD)
// ----------------------------------------------------------------
// buffers and characters
// ----------------------------------------------------------------
`define AMM_LINE_MAX    24
`define AMM_REPLY_BYTES 48
`define AMM_CH_CR       8'h0D
`define AMM_CH_LF       8'h0A
`define AMM_CH_ZERO     8'h30
`define AMM_CH_ONE      8'h31
`define AMM_CH_MINUS    8'h2D
`define AMM_CRLF        16'h0D0A
// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
`define AMM_ADDR_CTRL   4'h0
`define AMM_ADDR_STAT   4'h4
`define AMM_ADDR_TEMP   4'h8
`define AMM_CTRL_POL    0
`define AMM_CTRL_PULLUP 1
`define AMM_CTRL_RST    2'h1
// ----------------------------------------------------------------
// over-temperature points, degrees celsius
// ----------------------------------------------------------------
`define AMM_OT_TRIP     8'sh55
`define AMM_OT_RESET    8'sh4B
`endif

// File: amm_host_model.sv
// host terminal model: sends command lines and collects reply characters
// assumes the design clock and 8n1 framing at BIT_CYC clocks per bit
`timescale 1ns/100ps
module amm_host_model #(
  parameter int BIT_CYC = 8
) (
  input  wire logic clk_i,
  output logic      line_o,
  input  wire logic line_i
);
  logic [7:0] rx_q[$];
  logic [9:0] fr;
  logic [7:0] c;
  initial line_o = 1'b1;
  // ----------------------------------------
  // transmit, lsb first, idle high between characters
  // ----------------------------------------
  task automatic send_line(input string s, input int gap);
    for (int i = 0; i <= s.len(); i++)
    begin
      fr = {1'b1, (i == s.len()) ? 8'h0D : s[i], 1'b0};
      for (int b = 0; b < 10; b++)
      begin
        line_o <= fr[b];
        repeat (BIT_CYC) @(posedge clk_i);
      end
      repeat (gap) @(posedge clk_i);
    end
  endtask
  // ----------------------------------------
  // receive, mid-bit sampling, bad stop bit stored as '?'
  // ----------------------------------------
  initial
  begin
    forever
    begin
      @(negedge line_i);
      repeat (BIT_CYC / 2) @(posedge clk_i);
      for (int k = 0; k < 8; k++)
      begin
        repeat (BIT_CYC) @(posedge clk_i);
        c[k] = line_i;
      end
      repeat (BIT_CYC) @(posedge clk_i);
      rx_q.push_back((line_i === 1'b1) ? c : 8'h3F);
    end
  end
endmodule // amm_host_model

// File: amm_pkg.sv
// types of the amplifier monitor and silence controller
// assumes amm_defines.svh for all numeric constants
package amm_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} amm_rx_t;
  typedef logic [7:0] amm_char_t;
endpackage

// File: tb_amp_monitor_mute_control.sv
// self-checking bench of the amplifier monitor and silence controller
// assumes amm_host_model on the serial pins; the silence pad is modelled with its bias
`timescale 1ns/100ps
`include "amm_defines.svh"
module tb_amp_monitor_mute_control;
  import amm_pkg::*;
  localparam int         BITC = 8;
  localparam logic [4:0] OTX  = 5'h16;
  logic        clk_sys_i;
  logic        rst_i;
  logic [3:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wreq;
  logic        rxd;
  logic        txd;
  logic        pin_en;
  logic        pin_val;
  logic        pull_up;
  logic        pull_dn;
  logic        pa_en;
  amm_char_t   temp;
  amm_char_t   fwd;
  logic        unlock;
  logic [31:0] r;
  logic [1:0]  ctl;
  int          seed;
  int          error_cnt;
  int          num_checks;
  int          cyc = 0;
  int          tv[5] = '{85, 86, 80, 74, 90};
  string       ecmd[6] = '{"setmute", "setmute cmd 7", "setmute foo", "bogus", "",
                           "getfaultsgetfaultsgetfaults"};
  string       emsg[6] = '{"err Missing Parameter", "err Invalid Value",
                           "err Invalid Parameter", "err Invalid Command",
                           "err Invalid Command", "err Invalid Command"};
  wire logic   mute_pin = pin_en ? pin_val : pull_up;

  amm_ctrl_top #(.BIT_CYC(BITC)) i_dut (
    .clk_sys_i         (clk_sys_i),
    .rst_i             (rst_i),
    .avs_address_i     (adr),
    .avs_read_i        (rd),
    .avs_write_i       (wr),
    .avs_writedata_i   (wdat),
    .avs_byteenable_i  (be),
    .avs_readdata_o    (rdat),
    .avs_waitrequest_o (wreq),
    .rxd_i             (rxd),
    .txd_o             (txd),
    .mute_pin_i        (mute_pin),
    .pull_up_en_o      (pull_up),
    .pull_down_en_o    (pull_dn),
    .pa_en_o           (pa_en),
    .temp_i            (temp),
    .fwdpwr_i          (fwd),
    .pll_unlock_i      (unlock)
  );
  amm_host_model #(.BIT_CYC(BITC)) i_host (
    .clk_i  (clk_sys_i),
    .line_o (rxd),
    .line_i (txd)
  );
  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    adr  <= a;
    wdat <= d;
    be   <= b;
    rd   <= ~w;
    wr   <= w;
    @(posedge clk_sys_i);
    while (wreq !== 1'b0) @(posedge clk_sys_i);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic st(input int k, input logic e, input string nm);
    bus(1'b0, `AMM_ADDR_STAT, 32'h0, 4'hF);
    chk(nm, {31'h0, e}, {31'h0, r[k]});
  endtask
  function automatic logic exp_pa(input logic [1:0] c, input logic en, input logic v);
    return !((en ? v : c[`AMM_CTRL_PULLUP]) == c[`AMM_CTRL_POL]);
  endfunction
  task automatic cmd(input string s, input string m);
    string      exp;
    string      got;
    int         n;
    logic [7:0] ch;
    exp = {"<>", m, "<>"};
    got = "";
    n   = 0;
    i_host.send_line(s, $random(seed) & 3);
    while (i_host.rx_q.size() < exp.len() && n < 9000)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    repeat (12 * BITC) @(posedge clk_sys_i);
    while (i_host.rx_q.size() > 0)
    begin
      ch  = i_host.rx_q.pop_front();
      got = {got, (ch == 8'h0D) ? "<" : (ch == 8'h0A) ? ">" : $sformatf("%c", ch)};
    end
    num_checks++;
    if (got != exp)
    begin
      error_cnt++;
      $display("CHECK FAILED reply to %s expected %s seen %s", s, exp, got);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 55;
    error_cnt = 0;
    num_checks = 0;
    rst_i = 1'b1;
    {adr, rd, wr, wdat, be} = {4'h0, 2'h0, 32'h0, 4'hF};
    {pin_en, pin_val, unlock} = 3'h0;
    temp = 8'h19;
    fwd = 8'h00;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    chk("pull_down", 32'h1, pull_dn);
    chk("pa_en floating", 32'h1, pa_en);
    bus(1'b0, `AMM_ADDR_CTRL, 32'h0, 4'hF);
    chk("ctrl reset", 32'h1, r);
    bus(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    chk("unmapped", 32'h0, r);
    bus(1'b1, `AMM_ADDR_STAT, 32'hFFFFFFFF, 4'hF);
    bus(1'b1, `AMM_ADDR_CTRL, 32'h2, 4'hE);
    bus(1'b0, `AMM_ADDR_STAT, 32'h0, 4'hF);
    chk("stat", 32'h0, r);
    bus(1'b0, `AMM_ADDR_CTRL, 32'h0, 4'hF);
    chk("ctrl lane", 32'h1, r);
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      ctl = (i < 4) ? i[1:0] : r[1:0];
      pin_en <= (i >= 4) & r[2];
      pin_val <= r[3];
      bus(1'b1, `AMM_ADDR_CTRL, {30'h0, ctl}, 4'hF);
      repeat (4) @(posedge clk_sys_i);
      chk("pa_en", {31'h0, exp_pa(ctl, pin_en, pin_val)}, pa_en);
      chk("pull_up", {31'h0, ctl[1]}, pull_up);
      chk("pull_down", {31'h0, ~ctl[1]}, pull_dn);
      st(0, ~exp_pa(ctl, pin_en, pin_val), "stat silenced");
    end
    bus(1'b1, `AMM_ADDR_CTRL, 32'h1, 4'hF);
    pin_en <= 1'b1;
    pin_val <= 1'b0;
    cmd("getident", "ok pn PN00 swver 0.00 sn SN00");
    for (int i = 0; i < 6; i++)
      cmd(ecmd[i], emsg[i]);
    cmd("setmute cmd 1", "ok");
    bus(1'b0, `AMM_ADDR_STAT, 32'h0, 4'hF);
    chk("sw mute stat", 32'h9, r);
    chk("sw mute pa_en", 32'h0, pa_en);
    cmd("getfaults", "ok mute 1 overTemp 0 pll 0");
    cmd("resetfaults", "ok");
    chk("mute kept", 32'h0, pa_en);
    cmd("setmute cmd 0", "ok");
    chk("mute released", 32'h1, pa_en);
    for (int i = 0; i < 5; i++)
    begin
      temp <= amm_char_t'(tv[i]);
      repeat (4) @(posedge clk_sys_i);
      st(1, OTX[i], "overtemp");
    end
    cmd("resetfaults", "ok");
    st(1, 1'b1, "overtemp hot clear");
    temp <= 8'h50;
    cmd("resetfaults", "ok");
    st(1, 1'b0, "overtemp cool clear");
    r = $random(seed);
    fwd <= r[7:0];
    temp <= 8'hD8;
    unlock <= 1'b1;
    @(posedge clk_sys_i);
    unlock <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    st(2, 1'b1, "lock loss held");
    bus(1'b0, `AMM_ADDR_TEMP, 32'h0, 4'hF);
    chk("temp reg", 32'hFFFFFFD8, r);
    cmd("getstatus", $sformatf("ok fault 1 fwdpwr %0d revpwr 0 temp -40", $signed(fwd)));
    cmd("getfaults", "ok mute 0 overTemp 0 pll 1");
    cmd("resetfaults", "ok");
    st(2, 1'b0, "lock loss cleared");
    repeat (200) @(posedge clk_sys_i);
    chk("unsolicited chars", 32'h0, i_host.rx_q.size());
    summarize();
  end
endmodule // tb_amp_monitor_mute_control
